// *** srt_strip_readout.sv ***
// Behaviour
// - each strip shifts one per clock above threshold, zero below, into latency buffer
// - latency buffer keeps bits only for the trigger latency, then drops them
// - on trigger, ones within the window around trigger point give pulse height
// - on trigger, position of first one relative to window start gives arrival time
// - 128 channels, each pushes its height and time pair into three-deep FIFO
// - no ones near the trigger point pushes a null marker instead
// - readout pops oldest entry of every channel and sends it with its strip number unless it is a null marker
// - chips chained point to point on the serial pathway, forwarding data
// - chain data may flow in either direction on the pathway
// - readout strobe grants the first chip the right to send
// - every packet starts with header and ends with trailer, even without hits
// - after its packet a chip passes the token to the next chip
// - header carries a unique code marking the start of an event message
// - body holds fixed-length hit words of strip, height and time
// - a unique trailer pattern that hit data cannot match ends the body
// - card takes eight links and deserializes each into 16-bit words
// - link controller frames by header and trailer and extracts hit words
// - trailers counted per strobe; completion when count equals configured chips
// - final expected trailer raises the link done flag
// - all done flags pulse event ready and permit the next strobe
// - words written to buffer memory at serial word rate; about 500 events
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_strip_readout
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [`SRT_NUM_CH-1:0] strip_above,
  input wire logic l1_trigger,
  input wire logic token_in,
  input wire logic chain_dir,
  input wire logic ser_in_a,
  input wire logic ser_in_b,
  output logic ser_out_a,
  output logic ser_out_b,
  output logic token_out,
  input wire logic strobe_req,
  input wire logic [`SRT_NUM_LINKS-1:0] link_clk,
  input wire logic [`SRT_NUM_LINKS-1:0] link_data,
  input wire logic [`SRT_NUM_LINKS-1:0][`SRT_CHIPS_W-1:0] chips_per_link,
  output logic strobe_out,
  output logic strobe_permit,
  output logic event_ready,
  output logic [`SRT_NUM_LINKS-1:0] link_done,
  output logic mem_we,
  output logic [`SRT_BUF_ADDR_W-1:0] mem_addr,
  output srt_buf_word_t mem_data
);
  srt_top_state_t st_reg;
  srt_top_state_t st_next;
  logic [`SRT_NUM_LINKS-1:0] rx_valid;
  logic [`SRT_NUM_LINKS-1:0][`SRT_WORD_W-1:0] rx_word;
  logic [`SRT_NUM_LINKS-1:0] rx_done;

  // Strip index that follows s in the scan
  function automatic logic [`SRT_CH_W-1:0] srt_next_strip(input logic [`SRT_CH_W-1:0] s);
    return s + 7'h01;
  endfunction

  // High on the last strip of the chip
  function automatic logic srt_last_strip(input logic [`SRT_CH_W-1:0] s);
    return s == 7'(`SRT_NUM_CH - 1);
  endfunction

  always_comb
  begin
    logic pop_en;
    logic [`SRT_FIFO_CNT_W-1:0] c;
    srt_meas_t [`SRT_FIFO_DEPTH-1:0] f;
    srt_meas_t meas;
    srt_hit_word_t hw;
    srt_meas_t head;
    logic upstream;
    logic own_bit;
    logic sending;
    logic taken;
    pop_en = 1'b0;
    c = '0;
    f = '0;
    meas = '0;
    hw = '0;
    head = st_reg.ch[st_reg.scan].fifo[0];
    upstream = chain_dir ? ser_in_a : ser_in_b;
    own_bit = st_reg.shreg[`SRT_WORD_W-1];
    sending = 1'b0;
    taken = 1'b0;
    st_next = st_reg;
    st_next.token_out = 1'b0;
    st_next.strobe_out = 1'b0;
    st_next.event_ready = 1'b0;
    st_next.mem_we = 1'b0;

    // Packet sequencer of the chip
    case (st_reg.st)
      CHIP_IDLE:
      begin
        if (token_in)
        begin
          st_next.st = CHIP_HDR;
          st_next.shreg = `SRT_HDR_CODE;
          st_next.bitcnt = '0;
          st_next.scan = '0;
        end
      end
      CHIP_HDR, CHIP_HIT, CHIP_TRL:
      begin
        sending = 1'b1;
        st_next.shreg = {st_reg.shreg[`SRT_WORD_W-2:0], 1'b0};
        st_next.bitcnt = st_reg.bitcnt + 4'h1;
        if (st_reg.bitcnt == `SRT_LAST_BIT)
        begin
          if (st_reg.st == CHIP_TRL)
          begin
            st_next.st = CHIP_IDLE;
            st_next.token_out = 1'b1;
          end
          else if (st_reg.st == CHIP_HIT && srt_last_strip(st_reg.scan))
          begin
            st_next.st = CHIP_TRL;
            st_next.shreg = `SRT_TRL_CODE;
          end
          else
          begin
            st_next.st = CHIP_SCAN;
            if (st_reg.st == CHIP_HIT)
            begin
              st_next.scan = srt_next_strip(st_reg.scan);
            end
          end
        end
      end
      CHIP_SCAN:
      begin
        if (st_reg.ch[st_reg.scan].cnt != '0)
        begin
          pop_en = 1'b1;
        end
        if (pop_en && !head.is_null)
        begin
          hw.marker = 1'b0;
          hw.strip = st_reg.scan;
          hw.height = head.height;
          hw.atime = head.atime;
          st_next.shreg = hw;
          st_next.bitcnt = '0;
          st_next.st = CHIP_HIT;
        end
        else if (srt_last_strip(st_reg.scan))
        begin
          st_next.shreg = `SRT_TRL_CODE;
          st_next.bitcnt = '0;
          st_next.st = CHIP_TRL;
        end
        else
        begin
          st_next.scan = srt_next_strip(st_reg.scan);
        end
      end
      default:
      begin
        st_next.st = CHIP_IDLE;
      end
    endcase

    // Own bits while sending, else pass upstream bits on
    st_next.ser_out_a = !chain_dir && (sending ? own_bit : upstream);
    st_next.ser_out_b = chain_dir && (sending ? own_bit : upstream);

    // Strip channels
    for (int i = 0; i < `SRT_NUM_CH; i++)
    begin
      st_next.ch[i].lat = {st_reg.ch[i].lat[`SRT_LAT_DEPTH-2:0], strip_above[i]};
      meas.height = srt_win_count(st_reg.ch[i].lat);
      meas.atime = srt_first_one(st_reg.ch[i].lat);
      meas.is_null = (meas.height == 4'h0);
      c = st_reg.ch[i].cnt;
      f = st_reg.ch[i].fifo;
      if (pop_en && st_reg.scan == 7'(i))
      begin
        f[0] = f[1];
        f[1] = f[2];
        c = c - 2'h1;
      end
      if (l1_trigger && c < 2'(`SRT_FIFO_DEPTH))
      begin
        f[c] = meas;
        c = c + 2'h1;
      end
      st_next.ch[i].cnt = c;
      st_next.ch[i].fifo = f;
    end

    // Link pin synchronisers and bit strobes
    st_next.clk_s1 = link_clk;
    st_next.clk_s2 = st_reg.clk_s1;
    st_next.clk_s3 = st_reg.clk_s2;
    st_next.dat_s1 = link_data;
    st_next.dat_s2 = st_reg.dat_s1;
    st_next.dat_s3 = st_reg.dat_s2;
    for (int l = 0; l < `SRT_NUM_LINKS; l++)
    begin
      if (st_reg.clk_s2[l] == st_reg.clk_s3[l])
      begin
        st_next.clk_lvl[l] = st_reg.clk_s3[l];
      end
      if (st_reg.dat_s2[l] == st_reg.dat_s3[l])
      begin
        st_next.dat_lvl[l] = st_reg.dat_s3[l];
      end
      st_next.bit_stb[l] = st_next.clk_lvl[l] && !st_reg.clk_lvl[l];
      st_next.bit_val[l] = st_reg.dat_lvl[l];
    end

    // Hit words into the event buffer memory, lowest link first
    for (int l = 0; l < `SRT_NUM_LINKS; l++)
    begin
      if (st_reg.pend[l] && !taken)
      begin
        taken = 1'b1;
        st_next.pend[l] = 1'b0;
        st_next.mem_we = 1'b1;
        st_next.mem_addr = st_reg.wptr;
        st_next.mem_data.link = 3'(l);
        st_next.mem_data.word = st_reg.pword[l];
        st_next.wptr = (st_reg.wptr == `SRT_BUF_LAST) ? '0 : st_reg.wptr + 15'h0001;
      end
    end
    for (int l = 0; l < `SRT_NUM_LINKS; l++)
    begin
      if (rx_valid[l])
      begin
        st_next.pend[l] = 1'b1;
        st_next.pword[l] = rx_word[l];
      end
    end

    // Strobe issue and event completion
    if (strobe_req && st_reg.permit)
    begin
      st_next.strobe_out = 1'b1;
      st_next.permit = 1'b0;
    end
    if (st_reg.strobe_out)
    begin
      st_next.armed = 1'b1;
    end
    if (st_reg.armed && (&rx_done))
    begin
      st_next.armed = 1'b0;
      st_next.event_ready = 1'b1;
      st_next.permit = 1'b1;
    end
  end

  // Reset leaves the first strobe permitted
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.permit <= 1'b1;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  for (genvar g = 0; g < `SRT_NUM_LINKS; g++)
  begin : g_link
    srt_link_rx u_rx (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .bit_stb(st_reg.bit_stb[g]),
      .bit_val(st_reg.bit_val[g]),
      .clear(st_reg.strobe_out),
      .chips_expected(chips_per_link[g]),
      .word_valid(rx_valid[g]),
      .word_data(rx_word[g]),
      .done(rx_done[g]),
      .trailers()
    );
  end

  assign ser_out_a = st_reg.ser_out_a;
  assign ser_out_b = st_reg.ser_out_b;
  assign token_out = st_reg.token_out;
  assign strobe_out = st_reg.strobe_out;
  assign strobe_permit = st_reg.permit;
  assign event_ready = st_reg.event_ready;
  assign link_done = rx_done;
  assign mem_we = st_reg.mem_we;
  assign mem_addr = st_reg.mem_addr;
  assign mem_data = st_reg.mem_data;
endmodule

// *** srt_params.svh ***
`ifndef SRT_PARAMS_SVH
`define SRT_PARAMS_SVH

// Front-end chip geometry
`define SRT_NUM_CH 128
`define SRT_CH_W 7
`define SRT_FIFO_DEPTH 3
`define SRT_FIFO_CNT_W 2

// Latency buffer: bit 0 is the newest sample, the top bit the oldest
`define SRT_LAT_DEPTH 16
`define SRT_TRIG_POS 8
`define SRT_WIN_HALF 4
`define SRT_WIN_LO 4
`define SRT_WIN_HI 12

// Packet words
`define SRT_WORD_W 16
`define SRT_BIT_CNT_W 4
`define SRT_LAST_BIT 4'hf
`define SRT_HDR_CODE 16'hf0c3
`define SRT_TRL_CODE 16'he1b4

// Chain and card timing
`define SRT_SER_MHZ 80
`define SRT_WORD_MHZ (`SRT_SER_MHZ / `SRT_WORD_W)
`define SRT_CLK_MHZ 200

// Receiving card
`define SRT_NUM_LINKS 8
`define SRT_LINK_IDX_W 3
`define SRT_CHIPS_W 6
`define SRT_BUF_EVENTS 500
`define SRT_BUF_WORDS_PER_EVENT 64
`define SRT_BUF_ADDR_W 15
`define SRT_BUF_LAST 15'h7cff

`endif

// *** srt_pkg.sv ***
package srt_pkg;
`include "srt_params.svh"

  typedef struct packed {
    logic is_null;
    logic [3:0] height;
    logic [3:0] atime;
  } srt_meas_t;

  typedef struct packed {
    logic marker;
    logic [`SRT_CH_W-1:0] strip;
    logic [3:0] height;
    logic [3:0] atime;
  } srt_hit_word_t;

  typedef struct packed {
    logic [`SRT_LINK_IDX_W-1:0] link;
    logic [`SRT_WORD_W-1:0] word;
  } srt_buf_word_t;

  typedef struct packed {
    logic [`SRT_LAT_DEPTH-1:0] lat;
    logic [`SRT_FIFO_CNT_W-1:0] cnt;
    srt_meas_t [`SRT_FIFO_DEPTH-1:0] fifo;
  } srt_chan_t;

  typedef enum logic [2:0] {CHIP_IDLE, CHIP_HDR, CHIP_SCAN, CHIP_HIT, CHIP_TRL} srt_chip_state_t;
  typedef enum logic {LINK_HUNT, LINK_FRAME} srt_link_state_t;

  typedef struct packed {
    srt_chan_t [`SRT_NUM_CH-1:0] ch;
    srt_chip_state_t st;
    logic [`SRT_CH_W-1:0] scan;
    logic [`SRT_WORD_W-1:0] shreg;
    logic [`SRT_BIT_CNT_W-1:0] bitcnt;
    logic ser_out_a;
    logic ser_out_b;
    logic token_out;
    logic strobe_out;
    logic permit;
    logic armed;
    logic event_ready;
    logic [`SRT_NUM_LINKS-1:0] pend;
    logic [`SRT_NUM_LINKS-1:0][`SRT_WORD_W-1:0] pword;
    logic mem_we;
    logic [`SRT_BUF_ADDR_W-1:0] mem_addr;
    srt_buf_word_t mem_data;
    logic [`SRT_BUF_ADDR_W-1:0] wptr;
    logic [`SRT_NUM_LINKS-1:0] clk_s1;
    logic [`SRT_NUM_LINKS-1:0] clk_s2;
    logic [`SRT_NUM_LINKS-1:0] clk_s3;
    logic [`SRT_NUM_LINKS-1:0] clk_lvl;
    logic [`SRT_NUM_LINKS-1:0] dat_s1;
    logic [`SRT_NUM_LINKS-1:0] dat_s2;
    logic [`SRT_NUM_LINKS-1:0] dat_s3;
    logic [`SRT_NUM_LINKS-1:0] dat_lvl;
    logic [`SRT_NUM_LINKS-1:0] bit_stb;
    logic [`SRT_NUM_LINKS-1:0] bit_val;
  } srt_top_state_t;

  typedef struct packed {
    srt_link_state_t st;
    logic [`SRT_WORD_W-1:0] shreg;
    logic [`SRT_BIT_CNT_W-1:0] bitcnt;
    logic [`SRT_CHIPS_W-1:0] trailers;
    logic done;
    logic word_valid;
    logic [`SRT_WORD_W-1:0] word_data;
  } srt_link_state_s_t;

  // Ones inside the window around the trigger point
  function automatic logic [3:0] srt_win_count(input logic [`SRT_LAT_DEPTH-1:0] lat);
    logic [3:0] n;
    n = 4'h0;
    for (int k = `SRT_WIN_LO; k <= `SRT_WIN_HI; k++)
    begin
      n = n + {3'b000, lat[k]};
    end
    return n;
  endfunction

  // Offset of the oldest one in the window from the window start
  function automatic logic [3:0] srt_first_one(input logic [`SRT_LAT_DEPTH-1:0] lat);
    logic [3:0] t;
    t = 4'h0;
    for (int k = `SRT_WIN_LO; k <= `SRT_WIN_HI; k++)
    begin
      if (lat[k])
      begin
        t = 4'(k - `SRT_WIN_LO);
      end
    end
    return t;
  endfunction
endpackage

// *** srt_link_rx.sv ***
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_link_rx
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic bit_stb,
  input wire logic bit_val,
  input wire logic clear,
  input wire logic [`SRT_CHIPS_W-1:0] chips_expected,
  output logic word_valid,
  output logic [`SRT_WORD_W-1:0] word_data,
  output logic done,
  output logic [`SRT_CHIPS_W-1:0] trailers
);
  srt_link_state_s_t st_reg;
  srt_link_state_s_t st_next;

  always_comb
  begin
    logic [`SRT_WORD_W-1:0] sh;
    logic [`SRT_CHIPS_W-1:0] base;
    logic trl_seen;
    sh = {st_reg.shreg[`SRT_WORD_W-2:0], bit_val};
    base = clear ? '0 : st_reg.trailers;
    trl_seen = 1'b0;
    st_next = st_reg;
    st_next.word_valid = 1'b0;
    st_next.trailers = base;
    if (bit_stb)
    begin
      st_next.shreg = sh;
      case (st_reg.st)
        LINK_HUNT:
        begin
          if (sh == `SRT_HDR_CODE)
          begin
            st_next.st = LINK_FRAME;
            st_next.bitcnt = '0;
          end
        end
        LINK_FRAME:
        begin
          st_next.bitcnt = st_reg.bitcnt + 4'h1;
          if (st_reg.bitcnt == `SRT_LAST_BIT)
          begin
            if (sh == `SRT_TRL_CODE)
            begin
              trl_seen = 1'b1;
              st_next.st = LINK_HUNT;
            end
            else if (!sh[`SRT_WORD_W-1])
            begin
              st_next.word_valid = 1'b1;
              st_next.word_data = sh;
            end
          end
        end
        default:
        begin
          st_next.st = LINK_HUNT;
        end
      endcase
    end
    st_next.trailers = base + {{(`SRT_CHIPS_W-1){1'b0}}, trl_seen};
    // Set wins over the clear from the next strobe
    st_next.done = (trl_seen && st_next.trailers == chips_expected)
      || (st_reg.done && !clear);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign word_valid = st_reg.word_valid;
  assign word_data = st_reg.word_data;
  assign done = st_reg.done;
  assign trailers = st_reg.trailers;
endmodule

// *** srt_chk_props.sv ***
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_chk
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic strobe_req,
  input wire logic chain_dir,
  input wire logic ser_out_a,
  input wire logic ser_out_b,
  input wire logic token_out,
  input wire logic strobe_out,
  input wire logic strobe_permit,
  input wire logic event_ready,
  input wire logic [`SRT_NUM_LINKS-1:0] link_done,
  input wire logic mem_we,
  input wire logic [`SRT_BUF_ADDR_W-1:0] mem_addr,
  input wire srt_buf_word_t mem_data
);
  logic [`SRT_BUF_ADDR_W-1:0] nxt_reg;
  logic have_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Address the next write must use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nxt_reg <= '0;
      have_reg <= 1'b0;
    end
    else if (mem_we)
    begin
      nxt_reg <= (mem_addr == `SRT_BUF_LAST) ? '0 : mem_addr + 15'h0001;
      have_reg <= 1'b1;
    end
  end
  sequence s_grant;
    strobe_req && strobe_permit && ce;
  endsequence
  sequence s_strobe;
    ##1 (strobe_out && !strobe_permit);
  endsequence
  a_strobe_grant: assert property (s_grant |-> s_strobe)
    else $error("strobe not granted");
  a_strobe_refuse: assert property (!strobe_permit |=> !strobe_out)
    else $error("strobe while not permitted");
  a_strobe_pulse: assert property (strobe_out |=> !strobe_out)
    else $error("strobe longer than one cycle");
  a_ready_pulse: assert property (event_ready |=> !event_ready)
    else $error("ready longer than one cycle");
  a_ready_done: assert property (event_ready |-> $past(&link_done) && strobe_permit)
    else $error("ready without all done");
  a_done_clear: assert property (strobe_out |=> link_done == '0)
    else $error("done not cleared by strobe");
  a_mem_step: assert property (mem_we && have_reg |-> mem_addr == nxt_reg)
    else $error("write address not sequential");
  a_mem_hits: assert property (mem_we |-> !mem_data.word[15])
    else $error("non hit word written");
  a_side_quiet: assert property ($stable(chain_dir) |-> (chain_dir ? !ser_out_a : !ser_out_b))
    else $error("unselected side active");
  a_token_pulse: assert property (token_out |=> !token_out)
    else $error("token longer than one cycle");
endmodule
bind srt_strip_readout srt_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .strobe_req(strobe_req), .chain_dir(chain_dir), .ser_out_a(ser_out_a),
  .ser_out_b(ser_out_b), .token_out(token_out), .strobe_out(strobe_out),
  .strobe_permit(strobe_permit), .event_ready(event_ready), .link_done(link_done),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data));

// *** srt_link_far.sv ***
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_link_far
(
  output logic [`SRT_NUM_LINKS-1:0] link_clk,
  output logic [`SRT_NUM_LINKS-1:0] link_data
);
  initial
  begin
    link_clk = '0;
    link_data = '1;
  end
  // Bit set up on low clock, taken on rising edge, MSB first
  task automatic send_word(input logic [15:0] w);
    for (int b = 15; b >= 0; b--)
    begin
      link_data = {`SRT_NUM_LINKS{w[b]}};
      #40;
      link_clk = '1;
      #40;
      link_clk = '0;
    end
  endtask
  // One chip packet on every link; clock stands still afterwards
  task automatic send_pkt(input logic [15:0] hit);
    send_word(16'hf0c3);
    send_word(hit);
    send_word(16'h8123);
    send_word(16'he1b4);
    link_data = ~link_data;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "srt_params.svh"
module tb;
  import srt_pkg::*;
  logic clk, rst_n, ce, l1_trigger, token_in, chain_dir, ser_in_a, ser_in_b, strobe_req;
  logic [`SRT_NUM_CH-1:0] strip_above;
  logic [`SRT_NUM_LINKS-1:0][`SRT_CHIPS_W-1:0] chips_per_link;
  logic ser_out_a, ser_out_b, token_out, strobe_out, strobe_permit, event_ready, mem_we;
  logic [`SRT_NUM_LINKS-1:0] link_done, link_clk, link_data;
  logic [`SRT_BUF_ADDR_W-1:0] mem_addr;
  srt_buf_word_t mem_data;
  logic [15:0] osh;
  int errors, num_checks, n_wr, n_rdy, hdr, hit, trl, tok;
  localparam logic [15:0] HIT_W = 16'h0514;
  srt_strip_readout dut (.clk(clk), .rst_n(rst_n), .ce(ce), .strip_above(strip_above),
    .l1_trigger(l1_trigger), .token_in(token_in), .chain_dir(chain_dir),
    .ser_in_a(ser_in_a), .ser_in_b(ser_in_b), .ser_out_a(ser_out_a),
    .ser_out_b(ser_out_b), .token_out(token_out), .strobe_req(strobe_req),
    .link_clk(link_clk), .link_data(link_data), .chips_per_link(chips_per_link),
    .strobe_out(strobe_out), .strobe_permit(strobe_permit), .event_ready(event_ready),
    .link_done(link_done), .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data));
  srt_link_far far (.link_clk(link_clk), .link_data(link_data));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
    osh <= {osh[14:0], chain_dir ? ser_out_b : ser_out_a};
  always @(negedge clk)
  begin
    if (event_ready === 1'b1)
      n_rdy++;
    if (mem_we === 1'b1)
    begin
      check("mem_addr", mem_addr, n_wr);
      check("mem_data", mem_data, {3'(n_wr % 8), HIT_W});
      n_wr++;
    end
  end
  // Grant the token, then watch the packet on the selected side
  task automatic watch_packet();
    hdr = 0;
    hit = 0;
    trl = 0;
    tok = 0;
    @(negedge clk) token_in = 1'b1;
    @(negedge clk) token_in = 1'b0;
    for (int i = 0; i < 300; i++)
    begin
      @(negedge clk);
      if (osh === 16'hf0c3)
        hdr++;
      if (osh === HIT_W && hdr > 0 && trl == 0)
        hit += 1;
      if (osh === 16'h7f24 && hdr > 0 && trl == 0)
        hit += 16;
      if (osh === 16'he1b4 && hdr > 0)
        trl++;
      if (token_out === 1'b1 && {osh[14:0], chain_dir ? ser_out_b : ser_out_a} === 16'he1b4)
        tok++;
    end
  endtask
  task automatic test_chip_hits();
    chain_dir = 1'b0;
    @(negedge clk) ser_in_b = 1'b1;
    @(negedge clk) ser_in_b = 1'b0;
    check("forward_a", ser_out_a, 1);
    strip_above[5] = 1'b1;
    strip_above[127] = 1'b1;
    @(negedge clk) strip_above[5] = 1'b0;
    @(negedge clk) strip_above[127] = 1'b0;
    repeat (7) @(negedge clk);
    l1_trigger = 1'b1;
    @(negedge clk) l1_trigger = 1'b0;
    watch_packet();
    check("header", hdr, 1);
    check("hits", hit, 17);
    check("trailer", trl, 1);
    check("token", tok, 1);
    $display("test chip_hits done");
  endtask
  task automatic test_chip_empty();
    chain_dir = 1'b1;
    @(negedge clk) ser_in_a = 1'b1;
    @(negedge clk) ser_in_a = 1'b0;
    check("forward_b", ser_out_b, 1);
    l1_trigger = 1'b1;
    @(negedge clk) l1_trigger = 1'b0;
    watch_packet();
    check("empty_hdr", hdr, 1);
    check("empty_hits", hit, 0);
    check("empty_trl", trl, 1);
    check("empty_tok", tok, 1);
    $display("test chip_empty done");
  endtask
  task automatic strobe();
    @(negedge clk) strobe_req = 1'b1;
    @(negedge clk) strobe_req = 1'b0;
  endtask
  task automatic test_card();
    @(negedge clk) {ce, strobe_req} = 2'b01;
    repeat (2) @(negedge clk);
    check("ce_freeze", strobe_out, 0);
    check("ce_permit", strobe_permit, 1);
    {ce, strobe_req} = 2'b10;
    strobe();
    check("strobe", strobe_out, 1);
    check("permit_low", strobe_permit, 0);
    strobe();
    check("refused", strobe_out, 0);
    far.send_pkt(HIT_W);
    repeat (20) @(negedge clk);
    check("done_part", link_done, 8'hfe);
    check("no_ready", n_rdy, 0);
    check("writes_1", n_wr, 8);
    far.send_pkt(HIT_W);
    for (int i = 0; i < 40 && n_rdy == 0; i++)
      @(negedge clk);
    check("ready", n_rdy, 1);
    check("done_all", link_done, 8'hff);
    check("permit_back", strobe_permit, 1);
    check("writes_2", n_wr, 16);
    strobe();
    @(negedge clk);
    check("done_cleared", link_done, 0);
    $display("test card done");
  endtask
  initial
  begin
    #100000;
    errors++;
    close_out();
  end
  initial
  begin
    {errors, num_checks, n_wr, n_rdy} = '0;
    {ce, rst_n} = 2'b10;
    {l1_trigger, token_in, chain_dir, ser_in_a, ser_in_b, strobe_req} = '0;
    strip_above = '0;
    for (int i = 0; i < `SRT_NUM_LINKS; i++)
      chips_per_link[i] = (i == 0) ? 6'h02 : 6'h01;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    check("permit_rst", strobe_permit, 1);
    check("done_rst", link_done, 0);
    test_chip_hits();
    test_chip_empty();
    test_card();
    close_out();
  end
endmodule
